/* File: rtl/cas_map.vh */
`ifndef CAS_MAP_VH
`define CAS_MAP_VH

// command bytes of the registers served here
`define CAS_CMD_COMMON_STATUS 8'h02
`define CAS_CMD_FIRST_STATUS 8'h08
`define CAS_CMD_SECOND_STATUS 8'h09
`define CAS_CMD_THIRD_STATUS 8'h0a
`define CAS_CMD_FIRST_MASK 8'h0c
`define CAS_CMD_SECOND_MASK 8'h0d
`define CAS_CMD_THIRD_MASK 8'h0e

// power-on values of the mask bytes
`define CAS_FIRST_MASK_RST 3'h1
`define CAS_SECOND_MASK_RST 3'h0
`define CAS_THIRD_MASK_RST 3'h7

// channel field positions in status and mask bytes
`define CAS_BIT_LOCAL 0
`define CAS_BIT_REMOTE_A 1
`define CAS_BIT_REMOTE_B 2
`define CAS_CHAN_BITS 3

// summary flag positions in the common status byte
`define CAS_BIT_FIRST_SUM 1
`define CAS_BIT_SECOND_SUM 2
`define CAS_BIT_THIRD_SUM 3

// local limit keeps only its low seven bits, the top one reads zero
`define CAS_LOCAL_LIMIT_BITS 7

`endif

/* File: rtl/cas_flag.v */
`timescale 1ns/100ps
`default_nettype none

// one hysteresis alarm flag: set at or above limit, clear below limit minus hysteresis
module cas_flag (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire update,
  input wire [7:0] temp,
  input wire [7:0] limit,
  input wire [7:0] hyst,
  output reg flag_reg
);
  reg flag_next;
  wire [8:0] clear_level;

  // signed nine bits so a hysteresis above the limit never wraps into a huge threshold
  assign clear_level = {1'b0, limit} - {1'b0, hyst};

  always @* begin
    flag_next = flag_reg;
    if (update) begin
      if (temp >= limit) begin
        flag_next = 1'b1;
      end else if ($signed({1'b0, temp}) < $signed(clear_level)) begin
        flag_next = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
    end
  end
endmodule // cas_flag

`default_nettype wire

/* File: rtl/cas_mask.v */
`timescale 1ns/100ps
`default_nettype none

// one three-bit mask byte, upper bits are not stored
module cas_mask #(
  parameter [2:0] RESET_VAL = 3'h0
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire wr,
  input wire [7:0] wdata,
  output reg [2:0] mask_reg
);
  always @(posedge clk) begin
    if (!rst_n) begin
      mask_reg <= RESET_VAL;
    end else if (ce && wr) begin
      mask_reg <= wdata[2:0];
    end
  end
endmodule // cas_mask

`default_nettype wire

/* File: rtl/cas_alarm.v */
`timescale 1ns/100ps
`default_nettype none
`include "cas_map.vh"

// How it works
// - first status byte, three channel bits, rest zero
// - remote b first flag with hysteresis
// - remote a first flag with hysteresis
// - local flags set at limit, clear with hysteresis
// - first output active while any unmasked bit set
// - second status byte, remote second limits
// - remote a second/third flags use second limit
// - third status byte, same limits as second
// - second, third outputs follow own unmasked bits
// - first mask byte, reset one, rest zero
// - mask one blocks channel, zero passes it
// - common status summary bits one to three
// - second and third mask bytes, resets zero, seven
// - remote second limits shared by second, third
module cas_alarm (
  clk,
  rst_n,
  ce,
  local_temp,
  remote_a_temp,
  remote_b_temp,
  local_done,
  remote_a_done,
  remote_b_done,
  local_limit,
  remote_a_first_limit,
  remote_b_first_limit,
  remote_a_second_limit,
  remote_b_second_limit,
  hysteresis,
  reg_cmd,
  reg_wr,
  reg_wdata,
  reg_rd,
  reg_rdata,
  reg_rvalid,
  first_alarm_out_n,
  second_alarm_out_n,
  third_alarm_out_n
);
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire [7:0] local_temp;
  input wire [7:0] remote_a_temp;
  input wire [7:0] remote_b_temp;
  input wire local_done;
  input wire remote_a_done;
  input wire remote_b_done;
  input wire [7:0] local_limit;
  input wire [7:0] remote_a_first_limit;
  input wire [7:0] remote_b_first_limit;
  input wire [7:0] remote_a_second_limit;
  input wire [7:0] remote_b_second_limit;
  input wire [7:0] hysteresis;
  input wire [7:0] reg_cmd;
  input wire reg_wr;
  input wire [7:0] reg_wdata;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  output reg reg_rvalid;
  output reg first_alarm_out_n;
  output reg second_alarm_out_n;
  output reg third_alarm_out_n;

  wire [7:0] local_limit_eff;
  wire local_first_alarm_flag;
  wire remote_a_first_alarm_flag;
  wire remote_b_first_alarm_flag;
  wire local_second_alarm_flag;
  wire remote_a_second_alarm_flag;
  wire remote_b_second_alarm_flag;
  wire local_third_alarm_flag;
  wire remote_a_third_alarm_flag;
  wire remote_b_third_alarm_flag;
  wire [2:0] first_flags;
  wire [2:0] second_flags;
  wire [2:0] third_flags;
  wire [2:0] first_mask;
  wire [2:0] second_mask;
  wire [2:0] third_mask;
  wire first_alarm_summary_flag;
  wire second_alarm_summary_flag;
  wire third_alarm_summary_flag;
  wire wr_first_mask;
  wire wr_second_mask;
  wire wr_third_mask;
  reg [7:0] rdata_next;

  // any flag that its mask lets through drives the pin
  function alarm_any;
    input [2:0] flags;
    input [2:0] mask;
    begin
      alarm_any = |(flags & ~mask);
    end
  endfunction

  // the stored local limit has no top bit
  assign local_limit_eff = {1'b0, local_limit[`CAS_LOCAL_LIMIT_BITS-1:0]};

  // first alarm set, own remote limits
  cas_flag u_local_first (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(local_done),
    .temp(local_temp),
    .limit(local_limit_eff),
    .hyst(hysteresis),
    .flag_reg(local_first_alarm_flag)
  );

  cas_flag u_remote_a_first (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_a_done),
    .temp(remote_a_temp),
    .limit(remote_a_first_limit),
    .hyst(hysteresis),
    .flag_reg(remote_a_first_alarm_flag)
  );

  cas_flag u_remote_b_first (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_b_done),
    .temp(remote_b_temp),
    .limit(remote_b_first_limit),
    .hyst(hysteresis),
    .flag_reg(remote_b_first_alarm_flag)
  );

  // second alarm set
  cas_flag u_local_second (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(local_done),
    .temp(local_temp),
    .limit(local_limit_eff),
    .hyst(hysteresis),
    .flag_reg(local_second_alarm_flag)
  );

  cas_flag u_remote_a_second (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_a_done),
    .temp(remote_a_temp),
    .limit(remote_a_second_limit),
    .hyst(hysteresis),
    .flag_reg(remote_a_second_alarm_flag)
  );

  cas_flag u_remote_b_second (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_b_done),
    .temp(remote_b_temp),
    .limit(remote_b_second_limit),
    .hyst(hysteresis),
    .flag_reg(remote_b_second_alarm_flag)
  );

  // third alarm set reuses the second remote limits
  cas_flag u_local_third (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(local_done),
    .temp(local_temp),
    .limit(local_limit_eff),
    .hyst(hysteresis),
    .flag_reg(local_third_alarm_flag)
  );

  cas_flag u_remote_a_third (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_a_done),
    .temp(remote_a_temp),
    .limit(remote_a_second_limit),
    .hyst(hysteresis),
    .flag_reg(remote_a_third_alarm_flag)
  );

  cas_flag u_remote_b_third (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .update(remote_b_done),
    .temp(remote_b_temp),
    .limit(remote_b_second_limit),
    .hyst(hysteresis),
    .flag_reg(remote_b_third_alarm_flag)
  );

  assign first_flags = {remote_b_first_alarm_flag, remote_a_first_alarm_flag,
                        local_first_alarm_flag};
  assign second_flags = {remote_b_second_alarm_flag, remote_a_second_alarm_flag,
                         local_second_alarm_flag};
  assign third_flags = {remote_b_third_alarm_flag, remote_a_third_alarm_flag,
                        local_third_alarm_flag};

  // summary follows raw flags, not masked ones
  assign first_alarm_summary_flag = |first_flags;
  assign second_alarm_summary_flag = |second_flags;
  assign third_alarm_summary_flag = |third_flags;

  // writes to status commands decode to nothing, so they are dropped
  assign wr_first_mask = reg_wr && (reg_cmd == `CAS_CMD_FIRST_MASK);
  assign wr_second_mask = reg_wr && (reg_cmd == `CAS_CMD_SECOND_MASK);
  assign wr_third_mask = reg_wr && (reg_cmd == `CAS_CMD_THIRD_MASK);

  cas_mask #(
    .RESET_VAL(`CAS_FIRST_MASK_RST)
  ) u_first_mask (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_first_mask),
    .wdata(reg_wdata),
    .mask_reg(first_mask)
  );

  cas_mask #(
    .RESET_VAL(`CAS_SECOND_MASK_RST)
  ) u_second_mask (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_second_mask),
    .wdata(reg_wdata),
    .mask_reg(second_mask)
  );

  cas_mask #(
    .RESET_VAL(`CAS_THIRD_MASK_RST)
  ) u_third_mask (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_third_mask),
    .wdata(reg_wdata),
    .mask_reg(third_mask)
  );

  // read decode; unknown commands belong to other blocks and read zero here
  always @* begin
    rdata_next = 8'h00;
    if (reg_cmd == `CAS_CMD_COMMON_STATUS) begin
      rdata_next[`CAS_BIT_FIRST_SUM] = first_alarm_summary_flag;
      rdata_next[`CAS_BIT_SECOND_SUM] = second_alarm_summary_flag;
      rdata_next[`CAS_BIT_THIRD_SUM] = third_alarm_summary_flag;
    end else if (reg_cmd == `CAS_CMD_FIRST_STATUS) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = first_flags;
    end else if (reg_cmd == `CAS_CMD_SECOND_STATUS) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = second_flags;
    end else if (reg_cmd == `CAS_CMD_THIRD_STATUS) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = third_flags;
    end else if (reg_cmd == `CAS_CMD_FIRST_MASK) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = first_mask;
    end else if (reg_cmd == `CAS_CMD_SECOND_MASK) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = second_mask;
    end else if (reg_cmd == `CAS_CMD_THIRD_MASK) begin
      rdata_next[`CAS_CHAN_BITS-1:0] = third_mask;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // pins are active low and registered; one cycle behind the flags
  always @(posedge clk) begin
    if (!rst_n) begin
      first_alarm_out_n <= 1'b1;
      second_alarm_out_n <= 1'b1;
      third_alarm_out_n <= 1'b1;
    end else if (ce) begin
      first_alarm_out_n <= ~alarm_any(first_flags, first_mask);
      second_alarm_out_n <= ~alarm_any(second_flags, second_mask);
      third_alarm_out_n <= ~alarm_any(third_flags, third_mask);
    end
  end
endmodule // cas_alarm

`default_nettype wire

/* File: testbench/cas_alarm_props.sv */
`timescale 1ns/100ps
`default_nettype none
module cas_alarm_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic local_done,
  input wire logic remote_a_done,
  input wire logic remote_b_done,
  input wire logic first_alarm_out_n,
  input wire logic second_alarm_out_n,
  input wire logic third_alarm_out_n,
  input wire logic [7:0] reg_cmd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] remote_a_temp,
  input wire logic [7:0] remote_b_temp,
  input wire logic [7:0] remote_a_second_limit,
  input wire logic [7:0] remote_b_first_limit
);
  // shadow masks, so pin checks know which channels may pass
  logic [2:0] m1_reg, m2_reg, m3_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      m1_reg <= 3'h1;
      m2_reg <= 3'h0;
      m3_reg <= 3'h7;
    end else if (ce && reg_wr) begin
      if (reg_cmd == 8'h0c) m1_reg <= reg_wdata[2:0];
      if (reg_cmd == 8'h0d) m2_reg <= reg_wdata[2:0];
      if (reg_cmd == 8'h0e) m3_reg <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_ANSWER: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  AST_RD_PULSE: assert property (ce && !reg_rd |=> !reg_rvalid)
    else $error("read valid without read");
  AST_RSVD_ZERO: assert property (ce && reg_rd && (reg_cmd inside {8'h08, 8'h09, 8'h0a,
    8'h0c, 8'h0d, 8'h0e}) |=> reg_rdata[7:3] == 5'h00) else $error("reserved bits set");
  AST_COMMON_RSVD: assert property (ce && reg_rd && reg_cmd == 8'h02
    |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[0]) else $error("common status spare bits set");
  // a read in the cycle of a write to the same mask returns the old mask
  AST_MASK_READ: assert property (ce && reg_rd && reg_cmd == 8'h0c
    |=> reg_rdata == {5'h00, $past(m1_reg)}) else $error("first mask read wrong");
  AST_FIRST_SET: assert property (ce && remote_b_done
    && remote_b_temp >= remote_b_first_limit ##1 ce && !m1_reg[2] |=> !first_alarm_out_n)
    else $error("first pin not raised");
  AST_SECOND_SET: assert property (ce && remote_a_done
    && remote_a_temp >= remote_a_second_limit ##1 ce && !m2_reg[1] |=> !second_alarm_out_n)
    else $error("second pin not raised");
  AST_THIRD_BLOCK: assert property (ce && m3_reg == 3'h7 |=> third_alarm_out_n)
    else $error("masked third pin active");
  AST_HOLD: assert property (ce && !(local_done || remote_a_done || remote_b_done || reg_wr)
    ##1 ce |=> $stable({first_alarm_out_n, second_alarm_out_n, third_alarm_out_n}))
    else $error("pins moved without cause");
  COV_MASK_WR: cover property (ce && reg_wr && reg_cmd == 8'h0c);
  COV_FIRST: cover property ($fell(first_alarm_out_n));
  COV_SECOND: cover property ($fell(second_alarm_out_n));
  COV_THIRD: cover property ($fell(third_alarm_out_n));
endmodule // cas_alarm_props
bind cas_alarm cas_alarm_props i_cas_alarm_props (.*);
`default_nettype wire

/* File: testbench/cas_host.sv */
`timescale 1ns/100ps
`default_nettype none
// bus engine model on the decoded command port, drives at the falling edge
module cas_host (
  input wire logic clk,
  output logic [7:0] reg_cmd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_cmd = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clk);
    reg_cmd = cmd;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // idle lines never keep the last value
    reg_cmd = ~cmd;
    reg_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    @(negedge clk);
    reg_cmd = cmd;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_cmd = ~cmd;
    // a late answer comes back unknown and fails the compare
    data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule // cas_host
`default_nettype wire

/* File: testbench/tb_cas_alarm.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_cas_alarm;
  logic clk, rst_n, ce, local_done, remote_a_done, remote_b_done, reg_wr, reg_rd, reg_rvalid;
  logic first_alarm_out_n, second_alarm_out_n, third_alarm_out_n;
  logic [7:0] local_temp, remote_a_temp, remote_b_temp, local_limit, hysteresis, d;
  logic [7:0] remote_a_first_limit, remote_b_first_limit, remote_a_second_limit;
  logic [7:0] remote_b_second_limit, reg_cmd, reg_wdata, reg_rdata;
  int num_errors = 0;
  int compares = 0;
  cas_alarm i_cas_alarm (.*);
  cas_host i_cas_host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task test_done;
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rchk(input logic [7:0] c, input logic [7:0] exp);
    i_cas_host.rd(c, d);
    check8($sformatf("register %h", c), exp, d);
  endtask
  // expected pins in first, second, third order, active low
  task pchk(input logic [2:0] exp);
    repeat (2) @(negedge clk);
    check8("pins", {5'h00, exp},
           {5'h00, first_alarm_out_n, second_alarm_out_n, third_alarm_out_n});
  endtask
  task conv(input int ch, input logic [7:0] t);
    @(negedge clk);
    case (ch)
      0: local_temp = t;
      1: remote_a_temp = t;
      default: remote_b_temp = t;
    endcase
    {remote_b_done, remote_a_done, local_done} = 3'h1 << ch;
    @(negedge clk);
    {remote_b_done, remote_a_done, local_done} = 3'h0;
  endtask
  task t_reset;
    rchk(8'h0c, 8'h01);
    rchk(8'h0d, 8'h00);
    rchk(8'h0e, 8'h07);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    rchk(8'h0a, 8'h00);
    rchk(8'h02, 8'h00);
    pchk(3'b111);
  endtask
  task t_regs;
    i_cas_host.wr(8'h0c, 8'hfe);
    rchk(8'h0c, 8'h06);
    i_cas_host.wr(8'h08, 8'hff);
    rchk(8'h08, 8'h00);
    i_cas_host.wr(8'h07, 8'hff);
    rchk(8'h07, 8'h00);
    i_cas_host.wr(8'h0c, 8'h00);
  endtask
  task t_remote_b;
    conv(2, 8'h64);
    rchk(8'h08, 8'h04);
    rchk(8'h09, 8'h04);
    rchk(8'h0a, 8'h04);
    rchk(8'h02, 8'h0e);
    pchk(3'b001);
    i_cas_host.wr(8'h0d, 8'h04);
    pchk(3'b011);
    i_cas_host.wr(8'h0d, 8'h00);
    conv(2, 8'h5f);
    rchk(8'h08, 8'h04);
    conv(2, 8'h59);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h04);
    pchk(3'b101);
    conv(2, 8'h54);
    rchk(8'h0a, 8'h00);
    pchk(3'b111);
  endtask
  task t_remote_a;
    conv(1, 8'h55);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h02);
    rchk(8'h0a, 8'h02);
    conv(1, 8'h78);
    rchk(8'h08, 8'h02);
    conv(1, 8'h4b);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h02);
    conv(1, 8'h4a);
    rchk(8'h0a, 8'h00);
  endtask
  task t_local;
    conv(0, 8'h32);
    rchk(8'h08, 8'h01);
    rchk(8'h0a, 8'h01);
    pchk(3'b001);
    // only the local channel may reach the third pin now
    i_cas_host.wr(8'h0e, 8'hfe);
    rchk(8'h0e, 8'h06);
    pchk(3'b000);
    conv(0, 8'h2d);
    rchk(8'h09, 8'h01);
    conv(0, 8'h2c);
    rchk(8'h08, 8'h00);
    pchk(3'b111);
  endtask
  // a reading that changes without a finished conversion must not count
  task t_hold;
    @(negedge clk);
    remote_b_temp = 8'hc8;
    repeat (3) @(negedge clk);
    rchk(8'h08, 8'h00);
    pchk(3'b111);
  endtask
  // with the enable low a finished conversion and a mask write must both be lost
  task t_freeze;
    @(negedge clk);
    ce = 1'b0;
    conv(2, 8'hc8);
    i_cas_host.wr(8'h0c, 8'h07);
    @(negedge clk);
    ce = 1'b1;
    rchk(8'h08, 8'h00);
    rchk(8'h0c, 8'h00);
    pchk(3'b111);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {local_done, remote_a_done, remote_b_done} = 3'h0;
    {local_temp, remote_a_temp, remote_b_temp} = 24'h000000;
    local_limit = 8'hb2;
    remote_a_first_limit = 8'h78;
    remote_b_first_limit = 8'h64;
    remote_a_second_limit = 8'h50;
    remote_b_second_limit = 8'h5a;
    hysteresis = 8'h05;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_remote_b;
    t_remote_a;
    t_local;
    t_hold;
    t_freeze;
    test_done;
  end
endmodule // tb_cas_alarm
`default_nettype wire
